// [adc_seq_pkg.sv]
// constants shared by the converter sequencing control
`default_nettype none
package adc_seq_pkg;
	localparam int SAR_BITS = 10;
	localparam int RES_W = 16;
	localparam int NUM_CH = 8;
	localparam int CLK_MHZ = 200;

	localparam logic [7:0] OFS_CTRL_TWO = 8'h00;
	localparam logic [7:0] OFS_CTRL_THREE = 8'h04;
	localparam logic [7:0] OFS_CTRL_FOUR = 8'h08;
	localparam logic [7:0] OFS_CTRL_FIVE = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_TEST = 8'h18;
	localparam logic [2:0] RESULT_PAGE = 3'h1;

	localparam int JUSTIFY_POS = 7;
	localparam int SIGNED_POS = 6;
	localparam int FIFO_POS = 2;
	localparam int SINGLE_POS = 3;
	localparam int SETTLE_LSB = 0;
	localparam int SAMPLE_LSB = 8;
	localparam int CHAN_LSB = 0;
	localparam int REF_POS = 3;
	localparam int MULT_POS = 4;
	localparam int SCAN_POS = 5;
	localparam int EIGHT_POS = 6;
	localparam int SEQ_DONE_POS = 0;
	localparam int CONV_FLAG_LSB = 8;
	localparam int TEST_RST_POS = 16;

	localparam logic [15:0] CTRL_TWO_RST = 16'h0000;
	localparam logic [15:0] CTRL_THREE_RST = 16'h0000;
	localparam logic [15:0] CTRL_FOUR_RST = 16'h0301;
	localparam logic [15:0] CTRL_FIVE_RST = 16'h0000;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] MASK_RST = 16'h0000;

	localparam logic [3:0] LEN_SINGLE = 4'h1;
	localparam logic [3:0] LEN_FOUR = 4'h4;
	localparam logic [3:0] LEN_EIGHT = 4'h8;
	localparam logic [SAR_BITS-1:0] SAR_MSB = 10'h200;
	localparam logic [3:0] SAR_TOP_IDX = 4'h9;
endpackage
`default_nettype wire

// [adc_sar_engine.sv]
// successive-approximation engine for one conversion
`timescale 1ns/100ps
`default_nettype none
module adc_sar_engine
	import adc_seq_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic [7:0] i_sample_cycles,
	input wire logic [7:0] i_settle_cycles,
	input wire logic i_comp,
	output logic o_sample,
	output logic [SAR_BITS-1:0] o_dac,
	output logic o_done,
	output logic [SAR_BITS-1:0] o_result
);
	typedef enum logic [1:0]
	{
		s_idle = 2'b00,
		s_sample = 2'b01,
		s_trial = 2'b10
	} sar_state_e;

	sar_state_e state;
	logic comp_meta;
	logic comp_sync;
	logic [7:0] count;
	logic [3:0] bit_idx;

	// comparator comes from the analog side, so two flops first
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			comp_meta <= 1'b0;
			comp_sync <= 1'b0;
		end
		else
		begin
			comp_meta <= i_comp;
			comp_sync <= comp_meta;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state <= s_idle;
			count <= 8'h00;
			bit_idx <= 4'h0;
			o_sample <= 1'b0;
			o_dac <= 10'h000;
			o_done <= 1'b0;
			o_result <= 10'h000;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_abort)
			begin
				state <= s_idle;
				o_sample <= 1'b0;
			end
			else
			begin
				unique case (state)
					s_idle:
					begin
						if (i_start)
						begin
							state <= s_sample;
							count <= i_sample_cycles;
							o_sample <= 1'b1;
							o_dac <= 10'h000;
						end
					end
					s_sample:
					begin
						if (count == 8'h00)
						begin
							state <= s_trial;
							o_sample <= 1'b0;
							o_dac <= SAR_MSB;
							bit_idx <= SAR_TOP_IDX;
							count <= i_settle_cycles;
						end
						else
							count <= count - 8'h01;
					end
					s_trial:
					begin
						if (count == 8'h00)
						begin
							// comparator low means trial overshot
							o_dac[bit_idx] <= comp_sync;
							if (bit_idx == 4'h0)
							begin
								state <= s_idle;
								o_done <= 1'b1;
								o_result <= {o_dac[SAR_BITS-1:1], comp_sync};
							end
							else
							begin
								o_dac[bit_idx - 4'h1] <= 1'b1;
								bit_idx <= bit_idx - 4'h1;
								count <= i_settle_cycles;
							end
						end
						else
							count <= count - 8'h01;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [adc_sequence_control.sv]
// converter sequencing control with wishbone register file
`timescale 1ns/100ps
`default_nettype none
module adc_sequence_control
	import adc_seq_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic i_comp,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	output logic o_irq,
	output logic o_sample,
	output logic [SAR_BITS-1:0] o_dac,
	output logic [2:0] o_chan,
	output logic o_ref_sel
);
	typedef enum logic [1:0]
	{
		st_idle = 2'b00,
		st_launch = 2'b01,
		st_wait = 2'b10
	} seq_state_e;

	seq_state_e state;
	logic [15:0] ctrl_two;
	logic [15:0] ctrl_three;
	logic [15:0] ctrl_four;
	logic [15:0] ctrl_five;
	logic [15:0] status;
	logic [15:0] irq_mask;
	logic [RES_W-1:0] result [NUM_CH];
	logic [3:0] conv_idx;
	logic [2:0] fifo_ptr;
	logic [15:0] next_status_set;
	logic [15:0] next_status_clr;
	logic [31:0] next_rdata;
	logic bus_req;
	logic wr;
	logic wr_two;
	logic wr_three;
	logic wr_four;
	logic wr_five;
	logic wr_status;
	logic wr_mask;
	logic test_rst;
	logic restart;
	logic sar_abort;
	logic sar_start;
	logic sar_done;
	logic [SAR_BITS-1:0] sar_result;
	logic [3:0] seq_len;
	logic [2:0] slot;
	logic last_conv;

	// byte-lane merge for the 16-bit control registers
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_val,
		input logic [31:0] wdat,
		input logic [3:0] sel
	);
		lane_merge = old_val;
		if (sel[0])
			lane_merge[7:0] = wdat[7:0];
		if (sel[1])
			lane_merge[15:8] = wdat[15:8];
	endfunction

	// next channel inside a group of eight or of four
	function automatic logic [2:0] next_chan(
		input logic [2:0] chan,
		input logic eight
	);
		if (eight)
			next_chan = chan + 3'h1;
		else
			next_chan = {chan[2], chan[1:0] + 2'h1};
	endfunction

	// sign then justification of one raw conversion
	function automatic logic [RES_W-1:0] shape_result(
		input logic [SAR_BITS-1:0] raw,
		input logic justify,
		input logic sgn
	);
		logic [SAR_BITS-1:0] v;
		v = sgn ? {~raw[SAR_BITS-1], raw[SAR_BITS-2:0]} : raw;
		if (!justify)
			shape_result = {v, 6'h00};
		else if (sgn)
			shape_result = {{6{v[SAR_BITS-1]}}, v};
		else
			shape_result = {6'h00, v};
	endfunction

	assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr = bus_req && i_wb_we && (i_wb_sel != 4'h0);
	assign wr_two = wr && (i_wb_adr == OFS_CTRL_TWO);
	assign wr_three = wr && (i_wb_adr == OFS_CTRL_THREE);
	assign wr_four = wr && (i_wb_adr == OFS_CTRL_FOUR);
	assign wr_five = wr && (i_wb_adr == OFS_CTRL_FIVE);
	assign wr_status = wr && (i_wb_adr == OFS_STATUS);
	assign wr_mask = wr && (i_wb_adr == OFS_IRQ_MASK);
	assign test_rst = wr && (i_wb_adr == OFS_TEST) && i_wb_sel[2]
		&& i_wb_dat[TEST_RST_POS];
	assign restart = wr_four || wr_five;
	// control two/three writes stay out of the abort path
	assign sar_abort = restart || test_rst;
	assign sar_start = (state == st_launch) && !sar_abort;

	// sequence length; single conversion overrides the group size
	assign seq_len = ctrl_three[SINGLE_POS] ? LEN_SINGLE
		: (ctrl_five[EIGHT_POS] ? LEN_EIGHT : LEN_FOUR);
	assign slot = ctrl_three[FIFO_POS] ? fifo_ptr
		: conv_idx[2:0];
	assign last_conv = (conv_idx + 4'h1) == seq_len;

	// register file; reset values give legacy format and placement
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ctrl_two <= CTRL_TWO_RST;
			ctrl_three <= CTRL_THREE_RST;
			ctrl_four <= CTRL_FOUR_RST;
			ctrl_five <= CTRL_FIVE_RST;
			irq_mask <= MASK_RST;
		end
		else
		begin
			if (wr_two)
				ctrl_two <= lane_merge(ctrl_two, i_wb_dat, i_wb_sel);
			if (wr_three)
				ctrl_three <= lane_merge(ctrl_three, i_wb_dat, i_wb_sel);
			if (wr_four)
				ctrl_four <= lane_merge(ctrl_four, i_wb_dat, i_wb_sel);
			if (wr_five)
				ctrl_five <= lane_merge(ctrl_five, i_wb_dat, i_wb_sel);
			if (wr_mask)
				irq_mask <= lane_merge(irq_mask, i_wb_dat, i_wb_sel);
		end
	end

	// sequencer: start channel, stepping, scan repeat
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state <= st_idle;
			conv_idx <= 4'h0;
			o_chan <= 3'h0;
		end
		else if (test_rst)
			state <= st_idle;
		else if (restart)
		begin
			state <= st_launch;
			conv_idx <= 4'h0;
			// all three select bits taken, never masked
			o_chan <= wr_five ? i_wb_dat[CHAN_LSB +: 3]
				: ctrl_five[CHAN_LSB +: 3];
		end
		else
		begin
			unique case (state)
				st_idle:
					state <= st_idle;
				st_launch:
					state <= st_wait;
				st_wait:
				begin
					if (sar_done)
					begin
						state <= st_launch;
						if (last_conv)
						begin
							conv_idx <= 4'h0;
							o_chan <= ctrl_five[CHAN_LSB +: 3];
							if (!ctrl_five[SCAN_POS])
								state <= st_idle;
						end
						else
						begin
							conv_idx <= conv_idx + 4'h1;
							if (ctrl_five[MULT_POS])
								o_chan <= next_chan(o_chan,
									ctrl_five[EIGHT_POS]);
						end
					end
				end
				default:
					state <= st_idle;
			endcase
		end
	end

	// result slots; fifo mode keeps a running write pointer
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			fifo_ptr <= 3'h0;
			for (int i = 0; i < NUM_CH; i++)
				result[i] <= 16'h0000;
		end
		else if (sar_abort)
		begin
			if (wr_five || test_rst)
				fifo_ptr <= 3'h0;
		end
		else if ((state == st_wait) && sar_done)
		begin
			result[slot] <= shape_result(sar_result,
				ctrl_two[JUSTIFY_POS], ctrl_two[SIGNED_POS]);
			fifo_ptr <= fifo_ptr + 3'h1;
		end
	end

	// sticky flags: a set in the clearing cycle survives
	always_comb
	begin
		next_status_set = 16'h0000;
		next_status_clr = 16'h0000;
		if ((state == st_wait) && sar_done && !sar_abort)
		begin
			next_status_set[CONV_FLAG_LSB + slot] = 1'b1;
			// every sequence end, scan or not
			if (last_conv)
				next_status_set[SEQ_DONE_POS] = 1'b1;
		end
		if (wr_status)
			next_status_clr = lane_merge(16'h0000, i_wb_dat, i_wb_sel);
		if (wr_five || test_rst)
			next_status_clr = 16'hFFFF;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			status <= STATUS_RST;
		else
			status <= (status & ~next_status_clr) | next_status_set;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |(status & irq_mask);
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			o_ref_sel <= 1'b0;
		else
			o_ref_sel <= ctrl_five[REF_POS];
	end

	// read mux; unmapped addresses answer zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		// misaligned result reads answer zero like any unmapped address
		if ((i_wb_adr[7:5] == RESULT_PAGE) && (i_wb_adr[1:0] == 2'h0))
			next_rdata = {16'h0000, result[i_wb_adr[4:2]]};
		else
		begin
			unique case (i_wb_adr)
				OFS_CTRL_TWO:
					next_rdata = {16'h0000, ctrl_two};
				OFS_CTRL_THREE:
					next_rdata = {16'h0000, ctrl_three};
				OFS_CTRL_FOUR:
					next_rdata = {16'h0000, ctrl_four};
				OFS_CTRL_FIVE:
					next_rdata = {16'h0000, ctrl_five};
				OFS_STATUS:
					next_rdata = {16'h0000, status};
				OFS_IRQ_MASK:
					next_rdata = {16'h0000, irq_mask};
				OFS_TEST:
					next_rdata = {22'h00_0000, o_dac};
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// one wait state; ack drops the cycle after it is given
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end
		else
		begin
			o_wb_ack <= bus_req;
			if (bus_req && !i_wb_we)
				o_wb_dat <= next_rdata;
		end
	end

	adc_sar_engine u_sar
	(
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_start(sar_start),
		.i_abort(sar_abort),
		.i_sample_cycles(ctrl_four[SAMPLE_LSB +: 8]),
		.i_settle_cycles(ctrl_four[SETTLE_LSB +: 8]),
		.i_comp(i_comp),
		.o_sample(o_sample),
		.o_dac(o_dac),
		.o_done(sar_done),
		.o_result(sar_result)
	);
endmodule
`default_nettype wire

// [adc_seq_chk.sv]
// port checker for the converter sequencing control
`timescale 1ns/100ps
`default_nettype none
module adc_seq_chk
	import adc_seq_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic i_comp,
	input wire logic o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_irq,
	input wire logic o_sample,
	input wire logic [SAR_BITS-1:0] o_dac,
	input wire logic [2:0] o_chan,
	input wire logic o_ref_sel
);
	logic tk, wr, w5, w45, wtr, mapped, ref_exp;
	logic [15:0] mask;
	assign tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr = tk && i_wb_we;
	assign w5 = wr && i_wb_sel[0] && i_wb_adr == OFS_CTRL_FIVE;
	assign w45 = w5 || (wr && i_wb_sel[0] && i_wb_adr == OFS_CTRL_FOUR);
	assign wtr = wr && i_wb_sel[2] && i_wb_dat[TEST_RST_POS]
		&& i_wb_adr == OFS_TEST;
	assign mapped = i_wb_adr[1:0] == 2'h0
		&& (i_wb_adr <= OFS_TEST || i_wb_adr[7:5] == RESULT_PAGE);
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
			ref_exp <= 1'b0;
		else if (w5)
			ref_exp <= i_wb_dat[REF_POS];
	// byte lanes tracked so a partial mask write is judged right
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
			mask <= MASK_RST;
		else if (wr && i_wb_adr == OFS_IRQ_MASK)
		begin
			if (i_wb_sel[0])
				mask[7:0] <= i_wb_dat[7:0];
			if (i_wb_sel[1])
				mask[15:8] <= i_wb_dat[15:8];
		end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	a_ack_next: assert property (tk |=> o_wb_ack)
		else $error("ack late");
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack long");
	a_read_unmapped: assert property (tk && !i_wb_we && !mapped
		|=> o_wb_dat == 32'h0000_0000) else $error("unmapped read not 0");
	// sample field stays 3 in this bench, so four cycles high
	a_sample_len: assert property (disable iff (i_rst || w45 || wtr)
		$rose(o_sample) |-> o_sample [*4] ##1 !o_sample)
		else $error("sample phase length");
	a_restart_conv: assert property (
		w45 |-> ##[1:6] o_sample) else $error("no restart");
	a_test_idle: assert property (wtr |-> ##3 !o_sample [*8])
		else $error("not idle");
	a_ref_copy: assert property (w5 |-> ##2 o_ref_sel == ref_exp)
		else $error("ref select");
	a_chan_steady: assert property (o_sample && $past(o_sample)
		|-> $stable(o_chan)) else $error("channel moved while sampling");
	a_irq_masked: assert property ((mask == 16'h0000) [*3] |-> !o_irq)
		else $error("irq unmasked");
	c_restart: cover property (w5);
	c_irq: cover property ($rose(o_irq));
	c_test_rst: cover property (wtr);
endmodule
bind adc_sequence_control adc_seq_chk chk_u
(
	.i_ref_clk(i_ref_clk),
	.i_rst(i_rst),
	.i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we),
	.i_wb_adr(i_wb_adr),
	.i_wb_sel(i_wb_sel),
	.i_wb_dat(i_wb_dat),
	.i_comp(i_comp),
	.o_wb_ack(o_wb_ack),
	.o_wb_dat(o_wb_dat),
	.o_irq(o_irq),
	.o_sample(o_sample),
	.o_dac(o_dac),
	.o_chan(o_chan),
	.o_ref_sel(o_ref_sel)
);
`default_nettype wire

// [adc_comp_model.sv]
// comparator model for the analog channels and internal references
`timescale 1ns/100ps
`default_nettype none
module adc_comp_model
	import adc_seq_pkg::*;
(
	input wire logic [SAR_BITS-1:0] i_dac,
	input wire logic [2:0] i_chan,
	input wire logic i_ref_sel,
	output logic o_comp
);
	logic [SAR_BITS-1:0] lvl;
	// distinct level per source so a wrong channel shows in the result
	assign lvl = i_ref_sel ? 10'h3e8 - {7'h00, i_chan}
		: {i_chan, 7'h11};
	assign o_comp = lvl >= i_dac;
endmodule
`default_nettype wire

// [adc_sequence_control_test.sv]
// self-checking bench for the converter sequencing control
`timescale 1ns/100ps
`default_nettype none
module adc_sequence_control_test
	import adc_seq_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic ack, irq, smp, rsel, comp;
	logic [31:0] rdat, got;
	logic [SAR_BITS-1:0] dac;
	logic [2:0] chan;
	int num_errors = 0;
	int n_tests = 0;
	always #2.5 clk = ~clk;
	adc_sequence_control dut_u (.i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
		.i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .i_comp(comp), .o_wb_ack(ack), .o_wb_dat(rdat),
		.o_irq(irq), .o_sample(smp), .o_dac(dac), .o_chan(chan),
		.o_ref_sel(rsel));
	adc_comp_model comp_u (.i_dac(dac), .i_chan(chan), .i_ref_sel(rsel),
		.o_comp(comp));
	function automatic logic [15:0] lv(input logic [2:0] c, input logic r);
		return r ? 16'h03e8 - {13'h0000, c} : {6'h00, c, 7'h11};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		got = rdat;
		chk({31'h0, ack}, 32'h0000_0001);
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wait_seq;
		int n;
		n = 0;
		do
		begin
			bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
			n++;
		end
		while (got[SEQ_DONE_POS] !== 1'b1 && n < 300);
		chk({31'h0, got[SEQ_DONE_POS]}, 32'h0000_0001);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 500)
		begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, irq}, 32'h0000_0001);
	endtask
	task automatic slots(input logic [2:0] c0, input int n, input logic r,
		input logic w8);
		logic [2:0] c;
		for (int i = 0; i < n; i++)
		begin
			c = w8 ? c0 + i[2:0] : {c0[2], c0[1:0] + i[1:0]};
			bus(1'b0, 8'h20 + 8'(4 * i), 32'h0, 4'hf);
			chk(got, {10'h000, lv(c, r), 6'h00});
		end
	endtask
	task automatic t_reset;
		bus(1'b0, OFS_CTRL_TWO, 32'h0, 4'hf);
		chk(got, 32'h0000_0000);
		bus(1'b0, OFS_CTRL_THREE, 32'h0, 4'hf);
		chk(got, 32'h0000_0000);
		bus(1'b0, OFS_CTRL_FOUR, 32'h0, 4'hf);
		chk(got, 32'h0000_0301);
		bus(1'b1, 8'h1c, 32'hffff_ffff, 4'hf);
		bus(1'b0, 8'h1c, 32'h0, 4'hf);
		chk(got, 32'h0000_0000);
	endtask
	task automatic t_ctl4;
		bus(1'b1, OFS_CTRL_FOUR, 32'h0000_0303, 4'h3);
		repeat (10) @(posedge clk);
		wait_seq();
	endtask
	task automatic t_start_any;
		bus(1'b1, OFS_CTRL_THREE, 32'h0000_0008, 4'h3);
		bus(1'b1, OFS_CTRL_FIVE, 32'h0000_0015, 4'h3);
		wait_seq();
		chk(got, 32'h0000_0101);
		chk({29'h0, chan}, 32'h0000_0005);
		slots(3'h5, 1, 1'b0, 1'b0);
	endtask
	task automatic t_group4;
		bus(1'b1, OFS_CTRL_THREE, 32'h0000_0000, 4'h3);
		bus(1'b1, OFS_CTRL_FIVE, 32'h0000_0016, 4'h3);
		wait_seq();
		slots(3'h6, 4, 1'b0, 1'b0);
	endtask
	task automatic t_eight;
		bus(1'b1, OFS_CTRL_FIVE, 32'h0000_0055, 4'h3);
		wait_seq();
		slots(3'h5, 8, 1'b0, 1'b1);
	endtask
	task automatic t_ref;
		bus(1'b1, OFS_CTRL_THREE, 32'h0000_0008, 4'h3);
		bus(1'b1, OFS_CTRL_FIVE, 32'h0000_000a, 4'h3);
		wait_seq();
		chk({31'h0, rsel}, 32'h0000_0001);
		slots(3'h2, 1, 1'b1, 1'b0);
	endtask
	task automatic t_noabort;
		bus(1'b1, OFS_CTRL_FIVE, 32'h0000_0003, 4'h3);
		bus(1'b1, OFS_CTRL_TWO, 32'h0000_0080, 4'h3);
		wait_seq();
		bus(1'b0, 8'h20, 32'h0, 4'hf);
		chk(got, {16'h0000, lv(3'h3, 1'b0)});
		bus(1'b0, OFS_TEST, 32'h0, 4'hf);
		chk(got, {16'h0000, lv(3'h3, 1'b0)});
		chk({22'h0, dac}, {16'h0000, lv(3'h3, 1'b0)});
	endtask
	task automatic t_scan;
		bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001, 4'h3);
		bus(1'b1, OFS_CTRL_FIVE, 32'h0000_0022, 4'h3);
		wait_irq();
		bus(1'b1, OFS_STATUS, 32'h0000_0001, 4'h3);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		wait_irq();
		bus(1'b1, OFS_CTRL_FIVE, 32'h0000_0022, 4'h3);
		bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
		chk(got, 32'h0000_0000);
		bus(1'b1, OFS_IRQ_MASK, 32'h0000_0000, 4'h3);
		wait_seq();
		chk({31'h0, irq}, 32'h0000_0000);
	endtask
	// fifo placement: a control four restart keeps the write pointer
	task automatic t_fifo;
		logic [15:0] e;
		e = lv(3'h1, 1'b0) ^ 16'h0200;
		bus(1'b1, OFS_CTRL_TWO, 32'h0000_0040, 4'h3);
		bus(1'b1, OFS_CTRL_THREE, 32'h0000_000c, 4'h3);
		bus(1'b1, OFS_CTRL_FIVE, 32'h0000_0001, 4'h3);
		wait_seq();
		bus(1'b0, 8'h20, 32'h0, 4'hf);
		chk(got, {10'h000, e, 6'h00});
		bus(1'b1, OFS_STATUS, 32'h0000_ffff, 4'h3);
		bus(1'b1, OFS_CTRL_FOUR, 32'h0000_0303, 4'h3);
		wait_seq();
		bus(1'b0, 8'h24, 32'h0, 4'hf);
		chk(got, {10'h000, e, 6'h00});
	endtask
	task automatic t_test;
		bus(1'b1, OFS_TEST, 32'h0001_0000, 4'h4);
		bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
		chk(got, 32'h0000_0000);
		repeat (100) @(posedge clk);
		chk({31'h0, smp}, 32'h0000_0000);
	endtask
	task automatic end_sim;
		$display("errors %0d tests %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// generous span: the longest run is well under 10k cycles
	initial
	begin
		#300000;
		num_errors++;
		end_sim();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_ctl4();
		t_start_any();
		t_group4();
		t_eight();
		t_ref();
		t_noabort();
		t_scan();
		t_fifo();
		t_test();
		end_sim();
	end
endmodule
`default_nettype wire
